// file: logic/eeprom_guard.sv
`timescale 1ns/1ns
`default_nettype none

module eeprom_guard
	import eeprom_guard_pkg::*;
#(
	parameter int ADDR_W = 6,
	parameter int DATA_W = 16,
	parameter int WP_CYC = WP_CYCLES
) (
	input  wire logic clk,
	input  wire logic arst_n,
	input  wire logic cs,
	input  wire logic shift_clock,
	input  wire logic di,
	input  wire logic protect_pin,
	output wire logic data_out,
	output wire logic data_out_oe
);
	localparam int DEPTH = 1 << ADDR_W;
	localparam int SH_W  = DATA_W;
	localparam int CNT_W = 8;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_CMD    = 3'h1,
		ST_DATA   = 3'h2,
		ST_READ   = 3'h3,
		ST_LOADED = 3'h4,
		ST_DONE   = 3'h5
	} state_e;

	typedef struct packed {
		logic                         sk1, sk2, sk3;
		logic                         cs1, cs2, cs3;
		logic                         di1, di2;
		logic                         pe1, pe2;
		state_e                       st;
		logic [CNT_W-1:0]             cnt;
		logic [SH_W-1:0]              sh;
		logic [OP_W-1:0]              op;
		logic [ADDR_W-1:0]            addr;
		logic [DATA_W-1:0]            wdata;
		logic                         prog_en;
		logic                         locked;
		logic [ADDR_W:0]              bound;
		logic                         perase;
		logic [ADDR_W-1:0]            paddr;
		logic [DATA_W-1:0]            pdata;
		logic                         dout;
		logic                         dout_oe;
		logic [DEPTH-1:0][DATA_W-1:0] mem;
	} core_s;

	core_s r;
	core_s n;
	logic  rst_s1, rst_n_q;
	logic  sk_rise, cs_rise, cs_fall, start_d;
	logic  [1:0] ext;
	logic  [SH_W-1:0] sh_in;

	prog_if pg ();

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1  <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_s1  <= 1'b1;
			rst_n_q <= rst_s1;
		end
	end

	prog_timer #(.WP_CYC(WP_CYC)) u_timer (
		.rst_n (rst_n_q),
		.clk   (clk),
		.pg    (pg.timer)
	);

	// Pin edges, taken from second and third sync stages
	assign sk_rise  = r.sk2 & ~r.sk3;
	assign cs_rise  = r.cs2 & ~r.cs3;
	assign cs_fall  = ~r.cs2 & r.cs3;
	assign ext      = r.addr[ADDR_W-1 -: 2];
	assign sh_in    = {r.sh[SH_W-2:0], r.di2};
	assign pg.start = start_d;

	// ------------------------------------------------------------
	// Frame decode, guard and array update
	// ------------------------------------------------------------
	always_comb begin
		n       = r;
		start_d = 1'b0;
		{n.sk1, n.sk2, n.sk3} = {shift_clock, r.sk1, r.sk2};
		{n.cs1, n.cs2, n.cs3} = {cs, r.cs1, r.cs2};
		{n.di1, n.di2}        = {di, r.di1};
		{n.pe1, n.pe2}        = {protect_pin, r.pe1};
		n.dout_oe = r.cs2;

		// Finished programming cycle lands in the array
		if (pg.done) begin
			if (r.perase) begin
				n.mem[r.paddr] = '1;
			end else begin
				n.mem[r.paddr] = r.pdata;
			end
		end

		if (cs_rise) begin
			n.st  = ST_IDLE;
			n.cnt = '0;
		end else if (cs_fall) begin
			// Program only when the frame ended right after its last bit
			if (r.st == ST_LOADED) begin
				case (r.op)
				OP_WRITE, OP_ERASE: begin
					// Drop in disable mode or inside protected region
					if (r.prog_en && ({1'b0, r.addr} < r.bound)
					    && !pg.busy) begin
						start_d  = 1'b1;
						n.perase = (r.op == OP_ERASE);
						n.paddr  = r.addr;
						n.pdata  = r.wdata;
					end
				end
				OP_EXT: begin
					case (ext)
					EXT_EN:  n.prog_en = 1'b1;
					EXT_DIS: n.prog_en = 1'b0;
					EXT_PSET: begin
						if (r.pe2 && !r.locked) begin
							n.bound = r.wdata[ADDR_W:0];
						end
					end
					EXT_PLOCK: begin
						if (r.pe2) begin
							n.locked = 1'b1;
						end
					end
					default: n.prog_en = r.prog_en;
					endcase
				end
				default: n.st = ST_IDLE;
				endcase
			end
			n.st = ST_IDLE;
		end else if (r.cs2 && sk_rise && !pg.busy) begin
			case (r.st)
			ST_IDLE: begin
				if (r.di2) begin
					n.st  = ST_CMD;
					n.cnt = '0;
				end
			end
			ST_CMD: begin
				n.sh  = sh_in;
				n.cnt = r.cnt + CNT_W'(1);
				if (r.cnt == CNT_W'(OP_W + ADDR_W - 1)) begin
					n.op   = sh_in[ADDR_W+1 -: 2];
					n.addr = sh_in[ADDR_W-1:0];
					n.cnt  = '0;
					if (n.op == OP_READ) begin
						n.st   = ST_READ;
						n.sh   = r.mem[n.addr];
						n.dout = 1'b0;  // Dummy bit ahead of data
					end else if (n.op == OP_WRITE || (n.op == OP_EXT
					    && n.addr[ADDR_W-1 -: 2] == EXT_PSET)) begin
						n.st = ST_DATA;
					end else begin
						n.st = ST_LOADED;
					end
				end
			end
			ST_DATA: begin
				n.sh  = sh_in;
				n.cnt = r.cnt + CNT_W'(1);
				if (r.cnt == CNT_W'(DATA_W - 1)) begin
					n.wdata = sh_in;
					n.st    = ST_LOADED;
				end
			end
			ST_READ: begin
				n.dout = r.sh[SH_W-1];
				n.sh   = {r.sh[SH_W-2:0], 1'b0};
				n.cnt  = r.cnt + CNT_W'(1);
				if (r.cnt == CNT_W'(DATA_W - 1)) begin
					n.st = ST_DONE;
				end
			end
			ST_LOADED: n.st = ST_DONE;  // Late edge voids the request
			ST_DONE:   n.st = ST_DONE;
			default:   n.st = ST_IDLE;
			endcase
		end

		// Idle with chip select: show ready (1) or busy (0)
		if (r.cs2 && r.st == ST_IDLE) begin
			n.dout = ~pg.busy;
		end
	end

	// State register
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			r         <= '0;
			r.prog_en <= PROG_EN_RST;
			r.locked  <= LOCK_RST;
			r.bound   <= (ADDR_W + 1)'(DEPTH);
		end else begin
			r <= n;
		end
	end

	assign data_out    = r.dout;
	assign data_out_oe = r.dout_oe;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n_q);

	AST_PWRUP_DISABLED: assert property (
		$rose(rst_n_q) |-> !r.prog_en)
		else $error("Program enabled right after reset");

	AST_DISABLED_NO_CHANGE: assert property (
		(!r.prog_en && !pg.busy) |=> $stable(r.mem))
		else $error("Array changed in program disable mode");

	AST_PROTECTED_REFUSED: assert property (
		pg.done |-> ({1'b0, r.paddr} < r.bound && r.prog_en))
		else $error("Word landed inside protected region");

	AST_BOUND_NEEDS_PIN: assert property (
		(r.bound != $past(r.bound)) |-> ($past(r.pe2) && !$past(r.locked)))
		else $error("Protect boundary moved without pin or while locked");

	AST_SELF_TIMED: assert property (
		start_d |=> pg.busy [*8])
		else $error("Programming cycle ended too early");

	AST_DIRECT_WRITE: assert property (
		(pg.done && !r.perase) |=> (r.mem[$past(r.paddr)] == $past(r.pdata)))
		else $error("Write did not replace the word");

	AST_START_ON_CS_FALL: assert property (
		start_d |-> (cs_fall && r.st == ST_LOADED) ##1 pg.busy)
		else $error("Programming start not tied to chip select fall");

	AST_ENABLE_ONLY_BY_CMD: assert property (
		$rose(r.prog_en) |-> $past(cs_fall && r.st == ST_LOADED
		    && r.op == OP_EXT && ext == EXT_EN))
		else $error("Program enable without enable instruction");

endmodule

`default_nettype wire

// file: logic/eeprom_guard_pkg.sv
package eeprom_guard_pkg;

	// ------------------------------------------------------------
	// Instruction encoding
	// ------------------------------------------------------------
	localparam int         OP_W     = 2;
	localparam logic [1:0] OP_EXT   = 2'h0;  // Extended group, sub-code in address
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ  = 2'h2;
	localparam logic [1:0] OP_ERASE = 2'h3;

	// Extended sub-codes, top two address bits
	localparam logic [1:0] EXT_DIS   = 2'h0;  // program_disable_instruction
	localparam logic [1:0] EXT_PSET  = 2'h1;  // Load protect boundary (data word)
	localparam logic [1:0] EXT_PLOCK = 2'h2;  // Freeze boundary until the next reset
	localparam logic [1:0] EXT_EN    = 2'h3;  // Program enable

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int T_WP_NS       = 5000000;  // Self-timed programming time
	localparam int WP_CYCLES     = T_WP_NS / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic PROG_EN_RST = 1'h0;  // Power-up in program disable
	localparam logic LOCK_RST    = 1'h0;

endpackage

// file: logic/prog_if.sv
`timescale 1ns/1ns
`default_nettype none

// Start/busy/done handshake between frame logic and programming timer
interface prog_if;
	logic start;
	logic busy;
	logic done;

	modport ctrl  (output start, input  busy, input  done);
	modport timer (input  start, output busy, output done);
endinterface

`default_nettype wire

// file: logic/prog_timer.sv
`timescale 1ns/1ns
`default_nettype none

module prog_timer #(
	parameter int WP_CYC = 625000
) (
	input  wire logic rst_n,
	input  wire logic clk,
	prog_if.timer     pg
);
	localparam int CW = $clog2(WP_CYC + 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          busy;
		logic          done;
	} tmr_s;

	tmr_s r;
	tmr_s n;

	// ------------------------------------------------------------
	// Fixed-length count, the host has no way to alter it
	// ------------------------------------------------------------
	always_comb begin
		n      = r;
		n.done = 1'b0;
		if (!r.busy && pg.start) begin
			n.busy = 1'b1;
			n.cnt  = CW'(WP_CYC - 1);
		end else if (r.busy) begin
			if (r.cnt == '0) begin
				n.busy = 1'b0;
				n.done = 1'b1;
			end else begin
				n.cnt = r.cnt - CW'(1);
			end
		end
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign pg.busy = r.busy;
	assign pg.done = r.done;

endmodule

`default_nettype wire

// file: dv/eeprom_host.sv
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------
// Host side of the serial link
// ------------------------------------------------
module eeprom_host
	import eeprom_guard_pkg::*;
(
	input  wire logic clk,
	output var logic  cs,
	output var logic  shift_clock,
	output var logic  di,
	output var logic  protect_pin,
	input  wire logic data_out
);
	// Idle levels at time zero
	initial begin
		cs = 1'h0;
		shift_clock = 1'h0;
		di = 1'h0;
		protect_pin = 1'h0;
	end

	// Falling edges; levels stay five clocks for the synchronisers
	task automatic hold(input int n);
		repeat (n) @(negedge clk);
	endtask

	// One bit, taken by the device on the rise
	task automatic put(input logic b);
		di = b;
		hold(5);
		shift_clock = 1'h1;
		hold(5);
		shift_clock = 1'h0;
	endtask

	// Select, start bit, opcode, address
	task automatic head(input logic [1:0] op, input logic [5:0] a);
		cs = 1'h1;
		hold(5);
		put(1'h1);
		for (int i = 1; i >= 0; i--) put(op[i]);
		for (int i = 5; i >= 0; i--) put(a[i]);
	endtask

	// Deselect before any further rise; data line no longer valid
	task automatic fin();
		hold(5);
		cs = 1'h0;
		di = ~di;
		hold(5);
	endtask

	// Command frame with optional data word and stray clock
	task automatic cmd(input logic [1:0] op, input logic [5:0] a,
		input logic [15:0] d, input logic wd, input logic extra);
		head(op, a);
		if (wd) for (int i = 15; i >= 0; i--) put(d[i]);
		if (extra) put(1'h0);
		fin();
	endtask

	// Read frame, one bit out per rise after the dummy
	task automatic rd(input logic [5:0] a, output logic [15:0] d);
		head(OP_READ, a);
		for (int i = 15; i >= 0; i--) begin
			put(1'h0);
			d[i] = data_out;
		end
		fin();
	endtask

	// Idle select, count clocks until ready
	task automatic poll(output int n);
		cs = 1'h1;
		n = 0;
		hold(5);
		while (data_out !== 1'h1 && n < 100) begin
			hold(1);
			n++;
		end
		fin();
	endtask

	// Select with no clocks, status and enable settle meanwhile
	task automatic sel();
		cs = 1'h1;
		hold(5);
	endtask

	// Protect pin level change
	task automatic pin(input logic b);
		protect_pin = b;
		hold(5);
	endtask
endmodule

`default_nettype wire

// file: dv/testbench.sv
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------
// Self-checking bench
// ------------------------------------------------
module testbench
	import eeprom_guard_pkg::*;
;
	localparam int WP = 20; // Short programming time
	logic        clk = 1'h0;
	logic        arst_n = 1'h0;
	int          err_total = 0;
	int          checks_done = 0;
	int          cyc = 0;
	logic [15:0] v;
	wire logic   cs, shift_clock, di, protect_pin, data_out, data_out_oe;

	// Clock, 8 ns period
	always #4 clk = ~clk;

	eeprom_guard #(.WP_CYC(WP)) dut_u (
		.clk(clk), .arst_n(arst_n), .cs(cs), .shift_clock(shift_clock),
		.di(di), .protect_pin(protect_pin), .data_out(data_out),
		.data_out_oe(data_out_oe)
	);

	eeprom_host host_u (
		.clk(clk), .cs(cs), .shift_clock(shift_clock), .di(di),
		.protect_pin(protect_pin), .data_out(data_out)
	);

	// Compare and count
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Verdict and end of run
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Cut a hang short
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			err_total++;
			results();
		end
	end

	// Program frame, judged by the bounded busy period after it
	task automatic prog(input logic [1:0] op, input logic [5:0] a,
		input logic [15:0] d, input logic extra, input logic acc);
		int n;
		host_u.cmd(op, a, d, op == OP_WRITE, extra);
		host_u.poll(n);
		check(16'(n > 0 && n <= WP), 16'(acc));
	endtask

	// Read a word and compare
	task automatic expect_rd(input logic [5:0] a, input logic [15:0] e);
		host_u.rd(a, v);
		check(v, e);
	endtask

	// Output enable follows select; idle select shows ready
	task automatic t_select();
		check(16'(data_out_oe), 16'h0000);
		host_u.sel();
		check(16'(data_out_oe), 16'h0001);
		check(16'(data_out), 16'h0001);
		host_u.fin();
		check(16'(data_out_oe), 16'h0000);
	endtask

	// Second power-up in mid-run: disable mode again, array cleared
	task automatic t_repower();
		@(negedge clk);
		arst_n = 1'h0;
		repeat (4) @(negedge clk);
		arst_n = 1'h1;
		repeat (5) @(negedge clk);
		t_select();
		prog(OP_WRITE, 6'h07, 16'hbeef, 1'h0, 1'h0);
		expect_rd(6'h07, 16'h0000);
	endtask

	// Extended instruction, sub-code in the top address bits
	task automatic ext(input logic [1:0] sub, input logic [15:0] d);
		int n;
		host_u.cmd(OP_EXT, {sub, 4'h0}, d, sub == EXT_PSET, 1'h0);
		host_u.poll(n);
	endtask

	// Power-up state refuses programming
	task automatic t_powerup();
		prog(OP_WRITE, 6'h05, 16'h1234, 1'h0, 1'h0);
		prog(OP_ERASE, 6'h05, 16'h0000, 1'h0, 1'h0);
		expect_rd(6'h05, 16'h0000);
	endtask

	// Enable, direct overwrite, erase, stray clock
	task automatic t_direct();
		ext(EXT_EN, 16'h0000);
		prog(OP_WRITE, 6'h05, 16'ha5a5, 1'h0, 1'h1);
		expect_rd(6'h05, 16'ha5a5);
		prog(OP_WRITE, 6'h05, 16'h5a5a, 1'h0, 1'h1);
		expect_rd(6'h05, 16'h5a5a);
		prog(OP_ERASE, 6'h05, 16'h0000, 1'h0, 1'h1);
		expect_rd(6'h05, 16'hffff);
		prog(OP_WRITE, 6'h03, 16'h7777, 1'h1, 1'h0);
		expect_rd(6'h03, 16'h0000);
	endtask

	// Protected region, temporary then frozen
	task automatic t_protect();
		ext(EXT_PSET, 16'h0008);
		prog(OP_WRITE, 6'h0a, 16'h1111, 1'h0, 1'h1);
		host_u.pin(1'h1);
		ext(EXT_PSET, 16'h0008);
		prog(OP_WRITE, 6'h0a, 16'h2222, 1'h0, 1'h0);
		prog(OP_WRITE, 6'h07, 16'h0707, 1'h0, 1'h1);
		expect_rd(6'h0a, 16'h1111);
		ext(EXT_PSET, 16'h0040);
		prog(OP_WRITE, 6'h0a, 16'h3333, 1'h0, 1'h1);
		ext(EXT_PSET, 16'h0008);
		ext(EXT_PLOCK, 16'h0000);
		ext(EXT_PSET, 16'h0040);
		prog(OP_WRITE, 6'h0a, 16'h4444, 1'h0, 1'h0);
		expect_rd(6'h0a, 16'h3333);
	endtask

	// Disable before power-down; programming refused
	task automatic t_disable();
		ext(EXT_DIS, 16'h0000);
		prog(OP_WRITE, 6'h07, 16'hdead, 1'h0, 1'h0);
		expect_rd(6'h07, 16'h0707);
	endtask

	// Reset, then the scenarios
	initial begin
		repeat (4) @(negedge clk);
		arst_n = 1'h1;
		repeat (5) @(negedge clk);
		t_select();
		t_powerup();
		t_direct();
		t_protect();
		t_disable();
		t_repower();
		results();
	end
endmodule

`default_nettype wire
